/* rtl/fwsp_poller.sv */
// host-side poller of a parallel flash's program and erase status
// assumes a 10 MHz clock and flash pins sampled through two flops
//
// Summary of operation
// [RULE1] data poll valid after final write strobe
// [RULE2] programming shows inverted bit seven
// [RULE3] finished program shows true bit seven
// [RULE4] host polls at the programmed address
// [RULE5] protected program polls briefly then reads
// [RULE6] erase shows bit seven low, then high
// [RULE7] host polls inside a selected erase sector
// [RULE8] all-protected erase polls briefly then reads
// [RULE9] protected sectors skipped, status there unreliable
// [RULE10] trust all eight lines one read later
// [RULE11] reread bit seven after timeout flag
// [RULE12] open-drain ready/busy valid after command
// [RULE13] ready/busy low while programming or erasing
// [RULE14] bit six inverts every read while busy
// [RULE15] toggle valid from final write strobe
// [RULE16] all-protected erase toggles briefly
// [RULE17] protected program toggles briefly
// [RULE18] erase suspend stops toggle, program resumes it
// [RULE19] bit two toggles in selected erase sectors
// [RULE20] read twice and compare toggle bit
// [RULE21] toggle after timeout means failure, reset
// [RULE22] resumed polling restarts with double read
// [RULE23] bit five high on exceeded pulse limit
// [RULE24] status driven only when strobes low
`timescale 1ns/1ps
module fwsp_poller (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output fwsp_pkg::fwsp_pins_t      flashPins,
  input  wire logic [7:0]           flashDqIn,
  input  wire logic                 readyBusyIn
);

  // ==========================================================
  // register file
  fwsp_pkg::fwsp_cmd_t  cmd;
  fwsp_pkg::fwsp_stat_t stat;

  fwsp_axil_regs u_regs (
    .clock         (clock),
    .rst_b         (rst_b),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .cmd           (cmd),
    .stat          (stat)
  );

  // ==========================================================
  // pin synchronisers; the flash has no clock of ours
  logic [7:0] dqMeta, dqSync;
  logic       rbMeta, rbSync;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dqMeta <= 8'h00;
      dqSync <= 8'h00;
      rbMeta <= 1'b1;
      rbSync <= 1'b1;
    end else begin
      dqMeta <= flashDqIn;
      dqSync <= dqMeta;
      rbMeta <= readyBusyIn;  // shared pulled-up line, see [RULE12]
      rbSync <= rbMeta;
    end
  end

  // ==========================================================
  // poll sequencer
  fwsp_pkg::fwsp_state_t state, next_state;
  fwsp_pkg::fwsp_op_t    op, next_op;
  fwsp_pkg::fwsp_pins_t  next_pins;
  logic [3:0]  cnt, next_cnt;
  logic [31:0] pollAddr, next_pollAddr;
  logic [7:0]  data, next_data, firstDq, next_firstDq;
  logic expBit, next_expBit, readIdx, next_readIdx;
  logic recheck, next_recheck, finalRd, next_finalRd;
  logic pass, next_pass, fail, next_fail, sector, next_sector;

  // next values of sequencer and pins
  always_comb begin
    next_state    = state;
    next_op       = op;
    next_cnt      = cnt;
    next_pollAddr = pollAddr;
    next_data     = data;
    next_firstDq  = firstDq;
    next_expBit   = expBit;
    next_readIdx  = readIdx;
    next_recheck  = recheck;
    next_finalRd  = finalRd;
    next_pass     = pass;
    next_fail     = fail;
    next_sector   = sector;
    // strobes idle high and bus released unless a cycle runs
    next_pins     = '{addr: pollAddr, dqOut: 8'h00, dqOe: 1'b0,
                      ceB: 1'b1, oeB: 1'b1, weB: 1'b1};
    case (state)
      fwsp_pkg::S_IDLE: begin
        if (cmd.start) begin
          next_op       = cmd.op;
          next_pollAddr = cmd.addr;  // see [RULE4] see [RULE7]
          next_expBit   = cmd.expData[fwsp_pkg::POLL_BIT];
          next_pass     = 1'b0;
          next_fail     = 1'b0;
          next_sector   = 1'b0;
          next_readIdx  = 1'b0;
          next_recheck  = 1'b0;
          next_finalRd  = 1'b0;
          next_cnt      = 4'h0;
          next_state    = (cmd.op == fwsp_pkg::OP_RESET) ?
                          fwsp_pkg::S_WRITE : fwsp_pkg::S_READ;
        end
      end
      fwsp_pkg::S_READ: begin
        if (cnt == fwsp_pkg::RD_HOLD) begin
          next_data  = dqSync;
          next_cnt   = 4'h0;
          next_state = fwsp_pkg::S_DECIDE;
        end else begin
          next_cnt      = cnt + 4'h1;
          next_pins.ceB = 1'b0;  // both strobes low for status, see [RULE24]
          next_pins.oeB = 1'b0;
        end
      end
      fwsp_pkg::S_DECIDE: begin
        next_state = fwsp_pkg::S_READ;
        if (finalRd) begin
          // a later read carries valid data on all lines, see [RULE10]
          next_pass  = 1'b1;
          next_state = fwsp_pkg::S_IDLE;
        end else if (op == fwsp_pkg::OP_DATA_POLL) begin
          // true bit seven ends program or erase, see [RULE3] see [RULE6]
          if (data[fwsp_pkg::POLL_BIT] == expBit) begin
            next_finalRd = 1'b1;
          end else if (recheck) begin
            next_fail  = 1'b1;  // see [RULE11]
            next_state = fwsp_pkg::S_WRITE;
          end else if (data[fwsp_pkg::TIMEOUT_BIT]) begin
            next_recheck = 1'b1;  // see [RULE11] see [RULE23]
          end else if (cmd.pause) begin
            next_state = fwsp_pkg::S_PAUSE;
          end
        end else if (!readIdx) begin
          next_firstDq = data;  // first of the double read, see [RULE20]
          next_readIdx = 1'b1;
        end else begin
          if (data[fwsp_pkg::SECTOR_BIT]
              != firstDq[fwsp_pkg::SECTOR_BIT]) begin
            next_sector = 1'b1;  // sector toggle seen, see [RULE19]
          end
          if (data[fwsp_pkg::TOGGLE_BIT]
              == firstDq[fwsp_pkg::TOGGLE_BIT]) begin
            next_finalRd = 1'b1;  // see [RULE20] see [RULE14]
          end else if (recheck) begin
            next_fail  = 1'b1;  // still toggling, see [RULE21]
            next_state = fwsp_pkg::S_WRITE;
          end else if (data[fwsp_pkg::TIMEOUT_BIT]) begin
            next_recheck = 1'b1;  // see [RULE21]
            next_firstDq = data;
          end else begin
            next_readIdx = 1'b0;
            if (cmd.pause) begin
              next_state = fwsp_pkg::S_PAUSE;
            end
          end
        end
      end
      fwsp_pkg::S_WRITE: begin
        // reset command; data held one cycle past the strobe
        next_pins.addr  = 32'h0000_0000;
        next_pins.dqOut = fwsp_pkg::RESET_CMD;
        next_pins.dqOe  = 1'b1;
        next_cnt        = cnt + 4'h1;
        if (cnt < fwsp_pkg::WP_HOLD) begin
          next_pins.ceB = 1'b0;
          next_pins.weB = 1'b0;
        end else if (cnt > fwsp_pkg::WP_HOLD) begin
          next_pins.dqOe = 1'b0;
          next_cnt       = 4'h0;
          next_state     = fwsp_pkg::S_IDLE;
        end
      end
      fwsp_pkg::S_PAUSE: begin
        // resume always from a fresh double read, see [RULE22]
        next_readIdx = 1'b0;
        next_recheck = 1'b0;
        if (!cmd.pause) begin
          next_state = fwsp_pkg::S_READ;
        end
      end
      default: next_state = fwsp_pkg::S_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state     <= fwsp_pkg::S_IDLE;
      op        <= fwsp_pkg::OP_NONE;
      cnt       <= 4'h0;
      pollAddr  <= fwsp_pkg::ADDR_RST;
      data      <= 8'h00;
      firstDq   <= 8'h00;
      expBit    <= 1'b0;
      readIdx   <= 1'b0;
      recheck   <= 1'b0;
      finalRd   <= 1'b0;
      pass      <= 1'b0;
      fail      <= 1'b0;
      sector    <= 1'b0;
      flashPins <= '{addr: 32'h0000_0000, dqOut: 8'h00, dqOe: 1'b0,
                     ceB: 1'b1, oeB: 1'b1, weB: 1'b1};
    end else begin
      state     <= next_state;
      op        <= next_op;
      cnt       <= next_cnt;
      pollAddr  <= next_pollAddr;
      data      <= next_data;
      firstDq   <= next_firstDq;
      expBit    <= next_expBit;
      readIdx   <= next_readIdx;
      recheck   <= next_recheck;
      finalRd   <= next_finalRd;
      pass      <= next_pass;
      fail      <= next_fail;
      sector    <= next_sector;
      flashPins <= next_pins;
    end
  end

  // status toward software
  assign stat = '{busy: state != fwsp_pkg::S_IDLE, pass: pass, fail: fail,
                  ready: rbSync, sectorToggle: sector,
                  paused: state == fwsp_pkg::S_PAUSE, data: data};

  // ==========================================================
  // checks
  poll_address_a: assert property ( // see [RULE4] see [RULE7]
    @(posedge clock) disable iff (!rst_b)
    !flashPins.oeB |-> flashPins.addr == pollAddr)
    else $error("status read away from the poll address");

  late_data_a: assert property ( // see [RULE10]
    @(posedge clock) disable iff (!rst_b)
    $rose(pass) |-> $past(finalRd, 1) && $past(state, 1) == fwsp_pkg::S_DECIDE)
    else $error("pass reported without a later full read");

  recheck_fail_a: assert property ( // see [RULE11]
    @(posedge clock) disable iff (!rst_b)
    $rose(fail) |-> $past(recheck, 1))
    else $error("failure declared without a recheck");

  double_read_a: assert property ( // see [RULE20]
    @(posedge clock) disable iff (!rst_b)
    (op == fwsp_pkg::OP_TOGGLE_POLL && $rose(finalRd)) |-> $past(readIdx, 1))
    else $error("toggle judged on a single read");

  fail_reset_a: assert property ( // see [RULE21]
    @(posedge clock) disable iff (!rst_b)
    $rose(fail) |-> ##1 (!flashPins.weB && flashPins.dqOe
                         && flashPins.dqOut == fwsp_pkg::RESET_CMD))
    else $error("reset command not issued after failure");

  restart_poll_a: assert property ( // see [RULE22]
    @(posedge clock) disable iff (!rst_b)
    (state == fwsp_pkg::S_PAUSE && !cmd.pause)
      |=> state == fwsp_pkg::S_READ && !readIdx && !recheck)
    else $error("resumed polling skipped the first read");

  read_strobe_a: assert property ( // see [RULE24]
    @(posedge clock) disable iff (!rst_b)
    !flashPins.oeB |-> !flashPins.ceB && !flashPins.dqOe && flashPins.weB)
    else $error("read strobe with bus driven or write strobe");

  recheck_read_a: assert property ( // see [RULE11]
    @(posedge clock) disable iff (!rst_b)
    $rose(recheck) |-> state == fwsp_pkg::S_READ ##1 !flashPins.oeB)
    else $error("no new read after timeout flag");

endmodule : fwsp_poller

/* common/fwsp_pkg.sv */
// shared constants and types of the flash write status poller
// assumes one 10 MHz clock and software access over AXI4-Lite
package fwsp_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS  = 100;  // clock period
  localparam int READ_NS = 150;  // least time the flash needs to drive data
  localparam int WP_NS   = 100;  // least width of the write strobe
  localparam int RD_CYC  = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC  = (WP_NS + CLK_NS - 1) / CLK_NS;
  // two extra cycles cover the pin synchroniser
  localparam logic [3:0] RD_HOLD = 4'(RD_CYC + 2);
  localparam logic [3:0] WP_HOLD = 4'(WP_CYC);

  // ==========================================================
  // flash status bits and commands
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int SECTOR_BIT  = 2;
  localparam logic [7:0] RESET_CMD = 8'hF0;

  // ==========================================================
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_EXP  = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_DATA = 8'h10;
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_PAUSE_BIT = 2;
  localparam int ST_BUSY   = 0;
  localparam int ST_PASS   = 1;
  localparam int ST_FAIL   = 2;
  localparam int ST_READY  = 3;
  localparam int ST_SECTOR = 4;
  localparam int ST_PAUSED = 5;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [7:0]  EXP_RST  = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    OP_NONE        = 2'h0,
    OP_DATA_POLL   = 2'h1,
    OP_TOGGLE_POLL = 2'h2,
    OP_RESET       = 2'h3
  } fwsp_op_t;

  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_READ   = 5'h02,
    S_DECIDE = 5'h04,
    S_WRITE  = 5'h08,
    S_PAUSE  = 5'h10
  } fwsp_state_t;

  typedef struct packed {
    logic        start;
    fwsp_op_t    op;
    logic        pause;
    logic [31:0] addr;
    logic [7:0]  expData;
  } fwsp_cmd_t;

  typedef struct packed {
    logic       busy;
    logic       pass;
    logic       fail;
    logic       ready;
    logic       sectorToggle;
    logic       paused;
    logic [7:0] data;
  } fwsp_stat_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  dqOut;
    logic        dqOe;
    logic        ceB;
    logic        oeB;
    logic        weB;
  } fwsp_pins_t;

endpackage : fwsp_pkg

/* rtl/fwsp_axil_regs.sv */
// AXI4-Lite register file of the flash write status poller
// assumes the master keeps one write and one read in flight at most
`timescale 1ns/1ps
module fwsp_axil_regs (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output fwsp_pkg::fwsp_cmd_t    cmd,
  input  wire fwsp_pkg::fwsp_stat_t stat
);

  // ==========================================================
  // decode and byte merge
  function automatic logic isMapped(input logic [7:0] a, input logic wr);
    isMapped = (a == fwsp_pkg::OFF_CTRL) || (a == fwsp_pkg::OFF_ADDR)
            || (a == fwsp_pkg::OFF_EXP)
            || (!wr && ((a == fwsp_pkg::OFF_STAT)
                     || (a == fwsp_pkg::OFF_DATA)));
  endfunction : isMapped

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  logic        awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0]  awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0]  wStrb, next_wStrb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, ctrlWord, statWord;
  fwsp_pkg::fwsp_cmd_t next_cmd;

  // the slave takes address and data in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign ctrlWord = {29'h0000_0000, cmd.pause, cmd.op};
  always_comb begin
    statWord = 32'h0000_0000;
    statWord[fwsp_pkg::ST_BUSY]   = stat.busy;
    statWord[fwsp_pkg::ST_PASS]   = stat.pass;
    statWord[fwsp_pkg::ST_FAIL]   = stat.fail;
    statWord[fwsp_pkg::ST_READY]  = stat.ready;
    statWord[fwsp_pkg::ST_SECTOR] = stat.sectorToggle;
    statWord[fwsp_pkg::ST_PAUSED] = stat.paused;
  end

  // ==========================================================
  // next values of the bus and the registers
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp  = s_axi_rresp;
    next_rdata  = s_axi_rdata;
    next_cmd    = cmd;
    next_cmd.start = 1'b0;  // start is a single-cycle pulse
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = isMapped(awAddr, 1'b1) ? fwsp_pkg::RESP_OKAY
                                           : fwsp_pkg::RESP_SLVERR;
      case (awAddr)
        fwsp_pkg::OFF_CTRL: begin
          if (wStrb[0]) begin
            next_cmd.op    = fwsp_pkg::fwsp_op_t'(wData[1:0]);
            next_cmd.pause = wData[fwsp_pkg::CTRL_PAUSE_BIT];
            next_cmd.start = (wData[1:0] != fwsp_pkg::OP_NONE);
          end
        end
        fwsp_pkg::OFF_ADDR: next_cmd.addr = merge(cmd.addr, wData, wStrb);
        fwsp_pkg::OFF_EXP: begin
          if (wStrb[0]) begin
            next_cmd.expData = wData[7:0];
          end
        end
        default: ;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = isMapped(s_axi_araddr, 1'b0) ? fwsp_pkg::RESP_OKAY
                                                 : fwsp_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        fwsp_pkg::OFF_CTRL: next_rdata = ctrlWord;
        fwsp_pkg::OFF_ADDR: next_rdata = cmd.addr;
        fwsp_pkg::OFF_EXP:  next_rdata = {24'h00_0000, cmd.expData};
        fwsp_pkg::OFF_STAT: next_rdata = statWord;
        fwsp_pkg::OFF_DATA: next_rdata = {24'h00_0000, stat.data};
        default:            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      awHeld       <= 1'b0;
      awAddr       <= 8'h00;
      wHeld        <= 1'b0;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fwsp_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= fwsp_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      cmd          <= '{start: 1'b0, op: fwsp_pkg::OP_NONE, pause: 1'b0,
                        addr: fwsp_pkg::ADDR_RST,
                        expData: fwsp_pkg::EXP_RST};
    end else begin
      awHeld       <= next_awHeld;
      awAddr       <= next_awAddr;
      wHeld        <= next_wHeld;
      wData        <= next_wData;
      wStrb        <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
      cmd          <= next_cmd;
    end
  end

endmodule : fwsp_axil_regs

/* bench/fwsp_flash_model.sv */
// behavioural parallel flash answering status reads
// assumes host strobes arrive in the poller's pin struct
`timescale 1ns/1ps
module fwsp_flash_model (
  input  wire fwsp_pkg::fwsp_pins_t pins,
  input  wire logic                 go,
  input  wire logic                 erase,
  input  wire logic                 tmo,
  input  wire logic [7:0]           arr,
  input  wire logic [7:0]           reads,
  output logic [7:0]                dq,
  output logic                      readyBusy,
  output logic [31:0]               lastAddr
);
  // ==========================================================
  // busy state
  int         left = 0;
  logic       tog  = 1'b0;
  logic [7:0] outv = 8'h00;
  // a new operation stays busy for a set number of reads; with tmo set, until the reset command
  always @(posedge go) begin
    left = reads;
  end
  // the reset command ends whatever runs
  always @(negedge pins.weB) begin
    if (!pins.ceB && pins.dqOe && pins.dqOut === fwsp_pkg::RESET_CMD) begin
      left = 0;
    end
  end
  // toggle state lives between reads, flipped once per read while busy
  always @(negedge pins.oeB) begin
    if (!pins.ceB) begin
      lastAddr = pins.addr;
      if (left > 0) begin
        tog  = ~tog;
        outv = {erase ? 1'b0 : ~arr[7], tog, tmo, 1'b0, erase,
                erase & tog, 2'h0};
        if (!tmo) begin
          left = left - 1;
        end
      end else begin
        outv = arr; // no toggle once done
      end
    end
  end
  // no pull on data lines: released lines show the inverse
  assign dq = (!pins.ceB && !pins.oeB) ? outv : ~outv;
  // open drain with pull-up, low only while busy
  assign readyBusy = (left > 0) ? 1'b0 : 1'b1;
endmodule : fwsp_flash_model

/* bench/fwsp_poller_test.sv */
// self-checking bench of the flash status poller
// assumes the flash model beside it and AXI4-Lite access
`timescale 1ns/1ps
module fwsp_poller_test;
  // ==========================================================
  // signals
  typedef struct packed {
    logic [1:0] op;
    logic       erase;
    logic       tmo;
    logic [7:0] arr;
    logic [7:0] reads;
    logic [3:0] st;
  } fwsp_row_t;
  logic        clock = 1'b0, rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, arr = 8'h00, reads = 8'h00;
  logic [31:0] wdata = 32'h0, d, lastAddr;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, go = 1'b0;
  logic        erase = 1'b0, tmo = 1'b0, awready, wready, bvalid;
  logic        arready, rvalid, readyBusy;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  dq, flashDqIn;
  fwsp_pkg::fwsp_pins_t pins;
  int          err_count = 0, cmp_count = 0, cyc = 0;
  // status bits {sector, ready, fail, pass} expected per case
  fwsp_row_t   rows [7] = '{'{2'h1, 1'h0, 1'h0, 8'hA1, 8'h03, 4'h5},
    '{2'h1, 1'h0, 1'h0, 8'h38, 8'h02, 4'h5},
    '{2'h2, 1'h0, 1'h0, 8'hA1, 8'h03, 4'h5},
    '{2'h2, 1'h1, 1'h0, 8'hFF, 8'h04, 4'hD},
    '{2'h1, 1'h1, 1'h0, 8'hFF, 8'h02, 4'h5},
    '{2'h1, 1'h0, 1'h1, 8'h38, 8'h01, 4'h6},
    '{2'h2, 1'h0, 1'h1, 8'h38, 8'h01, 4'h6}};
  // the wire carries whoever drives it
  assign flashDqIn = pins.dqOe ? pins.dqOut : dq;
  always #50 clock = ~clock;
  // ==========================================================
  // instances
  fwsp_poller dut (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(d), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flashPins(pins), .flashDqIn(flashDqIn),
    .readyBusyIn(readyBusy));
  fwsp_flash_model flash (.pins(pins), .go(go), .erase(erase), .tmo(tmo),
    .arr(arr), .reads(reads), .dq(dq), .readyBusy(readyBusy),
    .lastAddr(lastAddr));
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = d;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic end_sim;
    $display("Mismatches %0d, compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end
  // ==========================================================
  // sequence: reset values and refusals, then table of polls, pause and mid-poll reset
  logic [31:0] v;
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    axr(fwsp_pkg::OFF_ADDR, v);
    chk(v, fwsp_pkg::ADDR_RST);
    axr(8'h20, v);
    chk({v[29:0], r}, {30'h0, fwsp_pkg::RESP_SLVERR});
    axw(fwsp_pkg::OFF_STAT, 32'h0000_00FF);
    chk({30'h0, r}, {30'h0, fwsp_pkg::RESP_SLVERR});
    foreach (rows[i]) begin
      @(posedge clock);
      erase <= rows[i].erase;
      tmo   <= rows[i].tmo;
      arr   <= rows[i].arr;
      reads <= rows[i].reads;
      go    <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      axw(fwsp_pkg::OFF_ADDR, 32'h100 + 32'(i));
      axw(fwsp_pkg::OFF_EXP, {24'h0, rows[i].arr});
      axw(fwsp_pkg::OFF_CTRL, {30'h0, rows[i].op});
      repeat (3) @(posedge clock);
      v = 32'h1;
      while (v[fwsp_pkg::ST_BUSY] !== 1'b0) axr(fwsp_pkg::OFF_STAT, v);
      chk({28'h0, v[4:1]}, {28'h0, rows[i].st});
      chk(lastAddr, 32'h100 + 32'(i));
      if (rows[i].st[0]) begin
        axr(fwsp_pkg::OFF_DATA, v);
        chk({24'h0, v[7:0]}, {24'h0, rows[i].arr});
      end
    end
    // ==========================================================
    // a paused toggle poll resumes with a fresh pair
    @(posedge clock);
    tmo   <= 1'b0;
    reads <= 8'h08;
    go    <= 1'b1;
    axw(fwsp_pkg::OFF_ADDR, 32'h200);
    go    <= 1'b0;
    axw(fwsp_pkg::OFF_CTRL, 32'h6);
    repeat (20) @(posedge clock);
    axr(fwsp_pkg::OFF_STAT, v);
    chk({26'h0, v[5:0]}, 32'h21);
    axw(fwsp_pkg::OFF_CTRL, 32'h2);
    v = 32'h1;
    while (v[fwsp_pkg::ST_BUSY] !== 1'b0) axr(fwsp_pkg::OFF_STAT, v);
    chk({26'h0, v[5:0]}, 32'h0A);
    // reset in mid-poll; the flash stays busy until the reset command
    reads <= 8'h20;
    go    <= 1'b1;
    axw(fwsp_pkg::OFF_CTRL, 32'h1);
    go    <= 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    // synchronisers refill before ready/busy is trusted
    repeat (3) @(posedge clock);
    axr(fwsp_pkg::OFF_STAT, v);
    chk(v, 32'h0);
    axw(fwsp_pkg::OFF_CTRL, 32'h3);
    repeat (6) @(posedge clock);
    axr(fwsp_pkg::OFF_STAT, v);
    chk(v, 32'h8);
    end_sim();
  end
endmodule : fwsp_poller_test
